// [serial_status_flags.sv]
// Status flag register of the serial port with APB slave and interrupt
// What this block does
// RULE1 - Eight-bit status register, documented bit order
// RULE2 - Writing one to clearable flags does nothing
// RULE3 - Zero clears only after reading flag set
// RULE4 - Transmit-end and received multiprocessor bit read-only
// RULE5 - Power-on reset and standby give 0x84
// RULE6 - Manual reset leaves status register unchanged
// RULE7 - Transmit-empty shows holding register has no data
// RULE8 - DMA write to holding register clears transmit-empty
// RULE9 - Transmit-enable low holds transmit-empty set
// RULE10 - Transfer to shift register sets transmit-empty
// RULE11 - Receive-full shows holding register has data
// RULE12 - Receive-enable clear keeps receive flags
// RULE13 - Receive-full sets on frame transfer
//
// The register addresses and the APB interface to the registers were decided locally.
`default_nettype none
module serial_status_flags
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        standby,
	input  wire logic        manual_reset,
	input  wire logic        dma_tx_write,
	input  wire logic        tx_load_shift,
	input  wire logic        rx_frame_done,
	input  wire logic        overrun_set,
	input  wire logic        framing_set,
	input  wire logic        parity_set,
	input  wire logic        tx_end_set,
	input  wire logic        tx_end_clear,
	input  wire logic        mp_rx_value,
	input  wire logic        mp_rx_load,
	output var  logic [7:0]  serial_status_reg,
	output var  logic        tx_enable_bit,
	output var  logic        rx_enable_bit,
	output var  logic        irq
);
	logic        setup;          // APB setup phase
	logic        wr_acc;         // Write access phase
	logic        rd_acc;         // Read access phase
	logic        mapped;         // Address decodes
	logic [7:0]  flags;          // Clearable flag outputs
	logic [7:0]  set_ev;         // Per-flag set events
	logic        st_rd;          // Status register read
	logic        st_wr;          // Status register write
	logic [7:0]  wdat;           // Low byte of write data
	logic        tx_end;         // Transmit-end flag
	logic        mp_rx;          // Received multiprocessor bit
	logic        mp_tx;          // Transmitted multiprocessor bit
	logic [status_flags_pkg::event_count-1:0] irq_st;   // Sticky events
	logic [status_flags_pkg::event_count-1:0] irq_msk;  // Event mask
	logic [7:0]  ctrl;           // Serial control register
	logic        next_tx_end;
	logic        next_mp_rx;
	logic        next_mp_tx;
	logic [7:0]  next_ctrl;
	logic [status_flags_pkg::event_count-1:0] next_irq_st;
	logic [status_flags_pkg::event_count-1:0] next_irq_msk;
	logic [status_flags_pkg::event_count-1:0] events;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	// Bus decode; slave answers one cycle after setup
	always_comb
	begin
		setup  = psel && !penable;
		wr_acc = psel && penable && pready && pwrite;
		rd_acc = psel && penable && pready && !pwrite;
		mapped = (paddr == status_flags_pkg::addr_status)
			|| (paddr == status_flags_pkg::addr_control)
			|| (paddr == status_flags_pkg::addr_irq_st)
			|| (paddr == status_flags_pkg::addr_irq_msk);
		st_rd  = rd_acc && (paddr == status_flags_pkg::addr_status);
		st_wr  = wr_acc && (paddr == status_flags_pkg::addr_status);
		wdat   = pwdata[7:0];
	end

	// Set events of the five clearable flags
	always_comb
	begin
		set_ev = 8'h00;
		// Transmitter disabled or data moved into the shift register
		set_ev[status_flags_pkg::bit_tx_empty] = !ctrl[status_flags_pkg::bit_tx_enable]
			|| tx_load_shift;                             // [RULE9] [RULE10]
		set_ev[status_flags_pkg::bit_rx_full]  = rx_frame_done;   // [RULE13] [RULE11]
		set_ev[status_flags_pkg::bit_overrun]  = overrun_set;
		set_ev[status_flags_pkg::bit_framing]  = framing_set;
		set_ev[status_flags_pkg::bit_parity]   = parity_set;
	end

	// One flag cell per clearable bit; a written one is ignored
	genvar g;
	generate
		for (g = 3; g < 8; g++)
		begin : gen_flag
			logic clr;
			always_comb
			begin
				// DMA write to holding register is a clear with no read needed
				if (g == status_flags_pkg::bit_tx_empty)
					clr = (st_wr && !wdat[g]) || dma_tx_write;     // [RULE8]
				else
					clr = st_wr && !wdat[g];                          // [RULE2]
			end
			flag_bit
			#(
				.reset_value (status_flags_pkg::status_reset[g])
			)
			u_flag
			(
				.pclk       (pclk),
				.presetn    (presetn),
				.init       (standby),
				.init_value (status_flags_pkg::status_reset[g]),
				.set_ev     (set_ev[g]),
				.read_seen  (st_rd || (g == status_flags_pkg::bit_tx_empty
					&& dma_tx_write)),
				.write_zero (clr),                                  // [RULE3]
				.flag       (flags[g])
			);
		end
		for (g = 0; g < 3; g++)
		begin : gen_unused
			assign flags[g] = 1'b0;
		end
	endgenerate

	// Read-only bits and the writable transmit multiprocessor bit
	always_comb
	begin
		next_tx_end = tx_end;
		next_mp_rx  = mp_rx;
		next_mp_tx  = mp_tx;
		if (standby)
		begin
			next_tx_end = status_flags_pkg::status_reset[status_flags_pkg::bit_tx_end]; // [RULE5]
			next_mp_rx  = 1'b0;
			next_mp_tx  = 1'b0;
		end
		else
		begin
			// Bus writes never touch these two bits
			if (tx_end_set)
				next_tx_end = 1'b1;                               // [RULE4]
			else if (tx_end_clear)
				next_tx_end = 1'b0;
			if (mp_rx_load)
				next_mp_rx = mp_rx_value;                         // [RULE4]
			if (st_wr)
				next_mp_tx = wdat[status_flags_pkg::bit_mp_tx];
		end
	end

	// Control, interrupt and bus answer next values
	always_comb
	begin
		next_ctrl    = ctrl;
		next_irq_msk = irq_msk;
		events[status_flags_pkg::ev_tx_empty] = set_ev[status_flags_pkg::bit_tx_empty]
			&& !flags[status_flags_pkg::bit_tx_empty];
		events[status_flags_pkg::ev_rx_full]  = rx_frame_done;
		events[status_flags_pkg::ev_error]    = overrun_set || framing_set || parity_set;
		next_irq_st  = irq_st;
		// Clearing receive-enable touches no receive flag
		if (wr_acc && paddr == status_flags_pkg::addr_control)
			next_ctrl = wdat;                                     // [RULE12]
		if (wr_acc && paddr == status_flags_pkg::addr_irq_msk)
			next_irq_msk = wdat[status_flags_pkg::event_count-1:0];
		if (wr_acc && paddr == status_flags_pkg::addr_irq_st)
			next_irq_st = irq_st & ~wdat[status_flags_pkg::event_count-1:0];
		// Set wins over a write-one clear
		next_irq_st  = next_irq_st | events;
		next_pready  = setup;
		next_pslverr = setup && !mapped;
		next_prdata  = 32'h0000_0000;
		if (setup)
		begin
			case (paddr)
				status_flags_pkg::addr_status:
					next_prdata = {24'h00_0000, flags[7:3], tx_end, mp_rx, mp_tx}; // [RULE1]
				status_flags_pkg::addr_control:
					next_prdata = {24'h00_0000, ctrl};
				status_flags_pkg::addr_irq_st:
					next_prdata = {29'h0000_0000, irq_st};
				status_flags_pkg::addr_irq_msk:
					next_prdata = {29'h0000_0000, irq_msk};
				default:
					next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Registers; only presetn and standby initialise the status bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_end  <= status_flags_pkg::status_reset[status_flags_pkg::bit_tx_end];
			mp_rx   <= 1'b0;
			mp_tx   <= 1'b0;
			ctrl    <= status_flags_pkg::control_reset;
			irq_st  <= '0;
			irq_msk <= '0;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			irq     <= 1'b0;
			serial_status_reg <= status_flags_pkg::status_reset;
			tx_enable_bit     <= 1'b0;
			rx_enable_bit     <= 1'b0;
		end
		else
		begin
			// Manual reset is deliberately not an input to any of these
			tx_end  <= next_tx_end;                               // [RULE6]
			mp_rx   <= next_mp_rx;
			mp_tx   <= next_mp_tx;
			ctrl    <= next_ctrl;
			irq_st  <= next_irq_st;
			irq_msk <= next_irq_msk;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
			irq     <= |(next_irq_st & next_irq_msk);
			// Mirror trails the flag state by one cycle; the bus read is exact
			serial_status_reg <= {flags[7:3], tx_end, mp_rx, mp_tx};       // [RULE7]
			tx_enable_bit     <= next_ctrl[status_flags_pkg::bit_tx_enable];
			rx_enable_bit     <= next_ctrl[status_flags_pkg::bit_rx_enable];
		end
	end

	// Inputs that this block must not react to: manual reset and the upper write-data bits
	logic unused_in;
	assign unused_in = manual_reset ^ (|pwdata[31:8]);

	// Checker state: receive-full has been read as one since it last rose
	logic rx_full_seen;
	logic next_rx_full_seen;

	// Seen drops whenever the flag is low, so each new rise needs a new read
	always_comb
	begin
		next_rx_full_seen = rx_full_seen;
		if (!flags[status_flags_pkg::bit_rx_full])
			next_rx_full_seen = 1'b0;
		else if (st_rd)
			next_rx_full_seen = 1'b1;
	end

	// Checker register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_full_seen <= 1'b0;
		else
			rx_full_seen <= next_rx_full_seen;
	end

	// Power-on value of the status register
	status_reset_a: assert property (@(posedge pclk)                       // [RULE5]
		$rose(presetn) |-> serial_status_reg == status_flags_pkg::status_reset)
		else $error("status register not at reset pattern after reset");

	// Transmitter disabled keeps transmit-empty high
	tx_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		!ctrl[status_flags_pkg::bit_tx_enable] && !standby |=> flags[7])
		else $error("transmit-empty cleared while transmitter disabled");

	// Receive frame completion sets receive-full next cycle
	rx_full_set_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
		rx_frame_done && !standby |=> flags[6])
		else $error("receive-full not set by frame");

	// Write of one never sets the overrun flag
	write_one_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		st_wr && !flags[5] && !overrun_set && !standby |=> !flags[5])
		else $error("overrun set by bus write");

	// A zero written to receive-full that software never read as one
	sequence unread_rx_clear_s;
		st_wr && !wdat[status_flags_pkg::bit_rx_full] && flags[status_flags_pkg::bit_rx_full]
			&& !rx_full_seen && !standby;
	endsequence

	// Zero without prior read leaves the flag
	clear_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
		unread_rx_clear_s |=> flags[status_flags_pkg::bit_rx_full])
		else $error("receive-full cleared without read");

	// DMA write clears transmit-empty
	dma_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		dma_tx_write && !set_ev[7] && !standby |=> !flags[7])
		else $error("dma write left transmit-empty set");

	// Bus writes leave transmit-end alone
	tx_end_ro_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		st_wr && !tx_end_set && !tx_end_clear && !standby |=> $stable(tx_end))
		else $error("transmit-end changed by write");

	// Shift load sets transmit-empty
	shift_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
		tx_load_shift && !standby |=> flags[7])
		else $error("transmit-empty not set on shift load");
endmodule
`default_nettype wire

// [status_flags_pkg.sv]
// Package: offsets, bit positions, reset values for the serial status flag block
`default_nettype none
package status_flags_pkg;
	// Register byte addresses on APB
	localparam logic [7:0] addr_status  = 8'h00;   // Serial status register
	localparam logic [7:0] addr_control = 8'h04;   // Serial control register
	localparam logic [7:0] addr_irq_st  = 8'h08;   // Sticky event status
	localparam logic [7:0] addr_irq_msk = 8'h0c;   // Event mask
	// Status bit positions
	localparam int bit_tx_empty = 7;
	localparam int bit_rx_full  = 6;
	localparam int bit_overrun  = 5;
	localparam int bit_framing  = 4;
	localparam int bit_parity   = 3;
	localparam int bit_tx_end   = 2;
	localparam int bit_mp_rx    = 1;
	localparam int bit_mp_tx    = 0;
	// Control bit positions
	localparam int bit_tx_enable = 0;
	localparam int bit_rx_enable = 1;
	// Reset values
	localparam logic [7:0] status_reset  = 8'h84;
	localparam logic [7:0] control_reset = 8'h00;
	// Flags cleared by read-then-write-zero
	localparam logic [7:0] clearable_mask = 8'hf8;
	// Event bit positions in the sticky register
	localparam int ev_tx_empty = 0;
	localparam int ev_rx_full  = 1;
	localparam int ev_error    = 2;
	localparam int event_count = 3;
endpackage
`default_nettype wire

// [flag_bit.sv]
// One clearable status flag with read-arm and set-wins-over-clear
`default_nettype none
module flag_bit
#(
	parameter logic reset_value = 1'b0   // Flag value at power-on reset
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic init,
	input  wire logic init_value,
	input  wire logic set_ev,
	input  wire logic read_seen,
	input  wire logic write_zero,
	output var  logic flag
);
	logic armed;      // Flag has been read as one
	logic next_flag;
	logic next_armed;

	// Next value: read arming, then standby init, set and clear in that order
	always_comb
	begin
		next_flag  = flag;
		next_armed = armed;
		// A read that sees the flag high arms it even if a set lands as well
		if (read_seen && flag)
		begin
			next_armed = 1'b1;
		end
		if (init)
		begin
			next_flag  = init_value;
			next_armed = 1'b0;
		end
		else if (set_ev)
		begin
			// Event wins over a clear in the same cycle
			next_flag = 1'b1;
		end
		else if (write_zero && (armed || read_seen))
		begin
			// Read and zero together are a forced clear, used by the DMA path
			next_flag  = 1'b0;
			next_armed = 1'b0;
		end
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag  <= reset_value;
			armed <= 1'b0;
		end
		else
		begin
			flag  <= next_flag;
			armed <= next_armed;
		end
	end
endmodule
`default_nettype wire

// [line_partner.sv]
// Behavioural model of the remote line side issuing one-cycle event pulses
`default_nettype none
module line_partner
(
	input  wire logic       pclk,
	output var  logic [7:0] ev,
	output var  logic       mpv
);
	timeunit 1ns;
	timeprecision 1ps;
	// Events idle until the bench asks for one
	initial
	begin
		ev = 8'h00;
		mpv = 1'b0;
	end
	// One event for exactly one cycle, launched just after an edge
	task automatic send(input int n, input logic v);
		@(posedge pclk);
		ev <= 8'h01 << n;
		mpv <= v;
		@(posedge pclk);
		ev <= 8'h00;
	endtask
endmodule
`default_nettype wire

// [tb_serial_status_flags.sv]
// Self-checking bench for the serial status flag block
`default_nettype none
module tb_serial_status_flags;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] st = status_flags_pkg::addr_status;
	localparam logic [7:0] ct = status_flags_pkg::addr_control;
	localparam logic [7:0] ist = status_flags_pkg::addr_irq_st;
	localparam logic [7:0] msk = status_flags_pkg::addr_irq_msk;
	// One table row: access, then the expected read-back
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic r;} row_t;
	row_t        rows [8];
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        standby, manual_reset, dma_tx_write, mpv, tx_en, rx_en, irq, err;
	logic [7:0]  ev, shown;
	int          fails, total_checks, cycles;
	serial_status_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .standby(standby), .manual_reset(manual_reset),
		.dma_tx_write(dma_tx_write), .tx_load_shift(ev[1]), .rx_frame_done(ev[0]),
		.overrun_set(ev[2]), .framing_set(ev[3]), .parity_set(ev[4]), .tx_end_set(ev[5]),
		.tx_end_clear(ev[6]), .mp_rx_value(mpv), .mp_rx_load(ev[7]),
		.serial_status_reg(shown), .tx_enable_bit(tx_en), .rx_enable_bit(rx_en), .irq(irq));
	line_partner p (.pclk(pclk), .ev(ev), .mpv(mpv));
	// Clock at 4 ns period
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Hang guard: far above the roughly 160 cycles the run needs
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			end_sim();
		end
	end
	// Verdict and end of run
	task automatic end_sim();
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Value comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// APB transfer: setup, then access held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Read one register and compare the low byte, upper bits zero
	task automatic rs(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk("prdata", {24'h000000, e}, rd);
	endtask
	// Wait a few edges for registered outputs to settle
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	initial
	begin
		{psel, penable, pwrite, standby, manual_reset, dma_tx_write} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		presetn = 1'b0;
		rows = '{'{1'b0, st, 8'h00, 8'h84, 1'b0}, '{1'b0, ct, 8'h00, 8'h00, 1'b0},
			'{1'b0, msk, 8'h00, 8'h00, 1'b0}, '{1'b1, st, 8'hff, 8'h85, 1'b0},
			'{1'b1, st, 8'h00, 8'h84, 1'b0}, '{1'b0, 8'h10, 8'h00, 8'h00, 1'b1},
			'{1'b1, 8'h10, 8'hff, 8'h00, 1'b1}, '{1'b1, ct, 8'h03, 8'h03, 1'b0}};
		idle(16);
		presetn <= 1'b1;
		// Table: reset values, write-one ignored, enable-low hold, unmapped
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk("pslverr", rows[i].r, err);
			if (rows[i].w)
				apb(1'b0, rows[i].a, 8'h00);
			chk("row read", {24'h000000, rows[i].e}, rd);
		end
		chk("tx_enable_bit", 32'h0000_0001, {31'h0, tx_en});
		chk("rx_enable_bit", 32'h0000_0001, {31'h0, rx_en});
		// DMA write clears, shift transfer sets transmit-empty
		@(posedge pclk) dma_tx_write <= 1'b1;
		@(posedge pclk) dma_tx_write <= 1'b0;
		rs(st, 8'h04);
		p.send(1, 1'b0);
		rs(st, 8'h84);
		// Zero without prior read leaves receive-full set
		p.send(0, 1'b0);
		apb(1'b1, st, 8'h80);
		rs(st, 8'hc4);
		apb(1'b1, st, 8'h80);
		rs(st, 8'h84);
		// Errors survive receive-enable clear, then clear after read
		p.send(2, 1'b0);
		p.send(3, 1'b0);
		p.send(0, 1'b0);
		apb(1'b1, ct, 8'h01);
		rs(st, 8'hf4);
		chk("rx_enable_bit", 32'h0000_0000, {31'h0, rx_en});
		p.send(4, 1'b0);
		rs(st, 8'hfc);
		apb(1'b1, st, 8'h80);
		rs(st, 8'h84);
		// Read-only transmit-end and received multiprocessor bit
		p.send(6, 1'b0);
		apb(1'b1, st, 8'h84);
		rs(st, 8'h80);
		p.send(7, 1'b1);
		apb(1'b1, st, 8'h80);
		rs(st, 8'h82);
		p.send(5, 1'b0);
		rs(st, 8'h86);
		chk("serial_status_reg", 32'h0000_0086, {24'h0, shown});
		// Interrupt masked, raised, cleared, raised again, masked
		chk("irq", 1'b0, irq);
		apb(1'b1, msk, 8'h07);
		idle(2);
		chk("irq", 1'b1, irq);
		apb(1'b1, ist, 8'h07);
		idle(2);
		chk("irq", 1'b0, irq);
		p.send(0, 1'b0);
		idle(2);
		chk("irq", 1'b1, irq);
		apb(1'b1, msk, 8'h00);
		idle(2);
		chk("irq", 1'b0, irq);
		// Manual reset keeps flags, standby forces the reset pattern
		@(posedge pclk) manual_reset <= 1'b1;
		@(posedge pclk) manual_reset <= 1'b0;
		rs(st, 8'hc6);
		chk("serial_status_reg", 32'h0000_00c6, {24'h0, shown});
		@(posedge pclk) standby <= 1'b1;
		idle(2);
		rs(st, 8'h84);
		chk("serial_status_reg", 32'h0000_0084, {24'h0, shown});
		standby <= 1'b0;
		// Power-on reset in mid-run
		p.send(3, 1'b0);
		@(posedge pclk) presetn <= 1'b0;
		idle(2);
		presetn <= 1'b1;
		rs(st, 8'h84);
		rs(ct, 8'h00);
		chk("tx_enable_bit", 32'h0000_0000, {31'h0, tx_en});
		chk("serial_status_reg", 32'h0000_0084, {24'h0, shown});
		end_sim();
	end
endmodule
`default_nettype wire
